// ===== design/mwdt_pkg.sv
package mwdt_pkg;

   // register location on the extended special function register bus
   localparam logic [7:0] WDT_CSR_ADDR      = 8'hFB;

   // field positions
   localparam int         CLR_EN_BIT        = 0;
   localparam int         KEY_LSB           = 1;
   localparam int         KEY_MSB           = 6;
   localparam int         CAUSE_BIT         = 7;

   // field values
   localparam logic [5:0] DISABLE_KEY       = 6'h2A;
   localparam logic       ENABLE_RESET      = 1'b1;
   localparam logic       CAUSE_RESET       = 1'b0;

   // timing
   localparam int         CLK_HZ            = 50000000;
   localparam int         TICK_PERIOD_US    = 1000;
   localparam int         TICK_CYCLES       = CLK_HZ / 1000000 * TICK_PERIOD_US;
   localparam int         TIMEOUT_MS        = 128;
   localparam logic [7:0] TIMEOUT_TICKS     = 8'(TIMEOUT_MS - 1);
   localparam int         MCU_RST_CYCLES    = 16;

   // register bus request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mwdt_sfr_req_t;

endpackage : mwdt_pkg

// ===== design/mwdt_tick.sv
`timescale 1ns/10ps
// 1-ms tick prescaler; a pulse each time the divider wraps
module mwdt_tick #(
   parameter int TICK_CYCLES = mwdt_pkg::TICK_CYCLES
) (
   input  wire logic sys_clk,
   input  wire logic reset,
   input  wire logic run,
   output logic      tick
);
   localparam int    CW = $clog2(TICK_CYCLES);
   localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

   logic [CW-1:0] div;
   logic [CW-1:0] next_div;
   logic          next_tick;

   // divider holds while not running
   always_comb begin
      next_div  = div;
      next_tick = 1'b0;
      if (run) begin
         if (div == LAST) begin
            next_div  = '0;
            next_tick = 1'b1;
         end else begin
            next_div = div + CW'(1);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         div  <= '0;
         tick <= 1'b0;
      end else begin
         div  <= next_div;
         tick <= next_tick;
      end
   end
endmodule : mwdt_tick

// ===== design/mwdt_top.sv
`timescale 1ns/10ps
// What this block does
// - eight-bit counter advances once per one-millisecond tick
// - running and not restarted within 128 ms resets the microcontroller
// - debugger break with debug_enable set suspends counting; jump to application resumes it
// - runs after reset; stops only when key field is written 101010
// - register cleared only by power-up reset, never by USB reset
// - writing one to bit 0 clears counter; zero does nothing
// - bit 0 reads enable status, one running, reset value one
// - key field bits 6 to 1 always read as zeros
// - bit 7 reads one after watchdog reset, zero after power-up
// - writing one to bit 7 clears it; other values ignored
module mwdt_top #(
   parameter int TICK_CYCLES = mwdt_pkg::TICK_CYCLES // clock cycles per watchdog tick
) (
   input  wire logic                    sys_clk,
   input  wire logic                    reset,
   input  wire logic                    usb_reset,
   input  wire logic                    debug_enable,
   input  wire logic                    debug_break,
   input  wire logic                    app_jump,
   input  wire mwdt_pkg::mwdt_sfr_req_t sfr_req,
   output logic [7:0]                   sfr_rdata,
   output logic                         mcu_reset
);
   logic       wd_clear_enable_status;
   logic       wd_reset_cause;
   logic [7:0] watchdog_counter;
   logic       suspended;
   logic [4:0] rst_cnt;
   logic       tick;
   logic       next_enable;
   logic       next_cause;
   logic [7:0] next_counter;
   logic       next_suspended;
   logic [4:0] next_rst_cnt;
   logic       next_mcu_reset;
   logic [7:0] next_rdata;
   logic       csr_wr;
   logic       csr_rd;
   logic       timeout;
   logic       run;

   assign csr_wr  = sfr_req.wr && (sfr_req.addr == mwdt_pkg::WDT_CSR_ADDR);
   assign csr_rd  = sfr_req.rd && (sfr_req.addr == mwdt_pkg::WDT_CSR_ADDR);
   assign run     = wd_clear_enable_status && !suspended && !mcu_reset;
   assign timeout = run && tick
                    && (watchdog_counter == mwdt_pkg::TIMEOUT_TICKS);

   // millisecond prescaler
   mwdt_tick #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .sys_clk (sys_clk),
      .reset   (reset),
      .run     (run),
      .tick    (tick)
   );

   // control/status register; usb_reset deliberately not used here
   always_comb begin
      next_enable = wd_clear_enable_status;
      next_cause  = wd_reset_cause;
      if (csr_wr && sfr_req.wdata[mwdt_pkg::KEY_MSB:mwdt_pkg::KEY_LSB]
                    == mwdt_pkg::DISABLE_KEY) begin
         next_enable = 1'b0;
      end
      if (csr_wr && sfr_req.wdata[mwdt_pkg::CAUSE_BIT]) begin
         next_cause = 1'b0;
      end
      if (timeout) begin
         next_cause  = 1'b1; // set wins over clear
         next_enable = mwdt_pkg::ENABLE_RESET;
      end
   end

   // only power-up reset clears the register
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         wd_clear_enable_status <= mwdt_pkg::ENABLE_RESET;
         wd_reset_cause         <= mwdt_pkg::CAUSE_RESET;
      end else begin
         wd_clear_enable_status <= next_enable;
         wd_reset_cause         <= next_cause;
      end
   end

   // debugger suspension
   always_comb begin
      next_suspended = suspended;
      if (app_jump) begin
         next_suspended = 1'b0;
      end else if (debug_enable && debug_break) begin
         next_suspended = 1'b1;
      end
   end

   // counter and timeout reset pulse
   always_comb begin
      next_counter   = watchdog_counter;
      next_rst_cnt   = rst_cnt;
      next_mcu_reset = mcu_reset;
      if (timeout) begin
         next_counter   = '0;
         next_mcu_reset = 1'b1;
         next_rst_cnt   = 5'(mwdt_pkg::MCU_RST_CYCLES - 1);
      end else if (mcu_reset) begin
         next_counter = '0;
         if (rst_cnt == '0) begin
            next_mcu_reset = 1'b0;
         end else begin
            next_rst_cnt = rst_cnt - 5'h01;
         end
      end else if (csr_wr && sfr_req.wdata[mwdt_pkg::CLR_EN_BIT]) begin
         next_counter = '0;
      end else if (run && tick) begin
         next_counter = watchdog_counter + 8'h01;
      end
   end

   // read data: key field reads zero
   always_comb begin
      next_rdata = sfr_rdata;
      if (csr_rd) begin
         next_rdata = {wd_reset_cause, 6'h00, wd_clear_enable_status};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         suspended        <= 1'b0;
         watchdog_counter <= 8'h00;
         rst_cnt          <= 5'h00;
         mcu_reset        <= 1'b0;
         sfr_rdata        <= 8'h00;
      end else begin
         suspended        <= next_suspended;
         watchdog_counter <= next_counter;
         rst_cnt          <= next_rst_cnt;
         mcu_reset        <= next_mcu_reset;
         sfr_rdata        <= next_rdata;
      end
   end
endmodule : mwdt_top

// ===== dv/mwdt_mcu.sv
`timescale 1ns/10ps
// firmware side of the register bus; strobes last one cycle
module mwdt_mcu (
   input  wire logic                sys_clk,
   input  wire logic [7:0]          sfr_rdata,
   output mwdt_pkg::mwdt_sfr_req_t  sfr_req
);
   initial sfr_req = '0;
   // one access; read data is taken one edge after the strobe
   task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
      @(negedge sys_clk) sfr_req = '{w, !w, a, d};
      @(negedge sys_clk) sfr_req = '0;
      q = sfr_rdata;
   endtask : acc
endmodule : mwdt_mcu

// ===== dv/mwdt_monitor.sv
`timescale 1ns/10ps
// port relations of the watchdog register and reset output
module mwdt_monitor (
   input wire logic                    sys_clk,
   input wire logic                    reset,
   input wire mwdt_pkg::mwdt_sfr_req_t sfr_req,
   input wire logic [7:0]              sfr_rdata,
   input wire logic                    mcu_reset
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   // decoded register strobes
   wire hit = sfr_req.addr == mwdt_pkg::WDT_CSR_ADDR;
   wire rd  = hit && sfr_req.rd;
   wire wr  = hit && sfr_req.wr;
   wire key = sfr_req.wdata[6:1] == mwdt_pkg::DISABLE_KEY;
   // register read and reset checks
   a_key_reads_zero: assert property (sfr_rdata[6:1] == 6'h00)
      else $error("key field read nonzero");
   a_init_read: assert property ($past(reset, 2) && !$past(reset) && rd
                                 |=> sfr_rdata == 8'h01)
      else $error("first read not 01");
   a_read_holds: assert property (!rd |=> $stable(sfr_rdata))
      else $error("read data moved without read");
   a_reset_clears: assert property ($past(reset) |-> !mcu_reset && sfr_rdata == 8'h00)
      else $error("power reset left state");
   a_key_disables: assert property (wr && key ##2 rd |=> !sfr_rdata[0])
      else $error("key write left timer on");
   a_cause_clears: assert property (wr && sfr_req.wdata[7] && !mcu_reset ##2 rd
                                    |=> !sfr_rdata[7])
      else $error("cause bit not cleared");
   a_mcu_rst_held: assert property ($rose(mcu_reset) |-> mcu_reset [*8])
      else $error("mcu reset too short");
   a_wd_cause_set: assert property ($fell(mcu_reset) ##1 rd |=> sfr_rdata == 8'h81)
      else $error("cause or enable wrong after timeout");
   c_init_read: cover property ($past(reset, 2) && !$past(reset) && rd);
   c_timeout: cover property ($rose(mcu_reset));
   c_disable: cover property (wr && key);
   c_cause_write: cover property (wr && sfr_req.wdata[7]);
endmodule : mwdt_monitor

bind mwdt_top mwdt_monitor mwdt_monitor_i (.sys_clk(sys_clk), .reset(reset),
   .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .mcu_reset(mcu_reset));

// ===== dv/tb_mcu_watchdog_timer.sv
`timescale 1ns/10ps
module tb_mcu_watchdog_timer;
   logic                    sys_clk = 0, reset = 1, usb_reset = 0, app_jump = 0;
   logic                    debug_enable = 0, debug_break = 0, mcu_reset;
   logic [7:0]              q, sfr_rdata;
   int                      num_errors = 0, n_compared = 0;
   localparam int           TICK   = 4; // short tick so a timeout fits the run
   localparam int           TO_CYC = 128 * TICK;
   mwdt_pkg::mwdt_sfr_req_t sfr_req;
   always #10 sys_clk = ~sys_clk;
   mwdt_top #(.TICK_CYCLES(TICK)) mwdt_top_i (.sys_clk(sys_clk), .reset(reset),
      .usb_reset(usb_reset),
      .debug_enable(debug_enable), .debug_break(debug_break), .app_jump(app_jump),
      .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .mcu_reset(mcu_reset));
   mwdt_mcu mcu (.sys_clk(sys_clk), .sfr_rdata(sfr_rdata), .sfr_req(sfr_req));
   // compare and count
   task automatic chk(input string what, input logic [7:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // read one address, compare, close the test
   task automatic rd(input logic [7:0] a, exp, input string what);
      mcu.acc(1'b0, a, 8'h00, q);
      chk(what, q, exp);
      $display("test %s done", what);
   endtask : rd
   task automatic end_of_test;
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test
   // watchdog on the run
   initial begin
      #200000;
      num_errors++;
      end_of_test();
   end
   // main sequence; inputs move on the falling edge
   initial begin
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk) reset = 0;
      rd(8'hFB, 8'h01, "reset value");
      mcu.acc(1'b1, 8'hFB, 8'hD6, q);
      rd(8'hFB, 8'h01, "near key");
      rd(8'hFA, 8'h01, "other address");
      // clear, then let the counter run out
      mcu.acc(1'b1, 8'hFB, 8'h01, q);
      repeat (127 * TICK - 8) @(negedge sys_clk);
      chk("early reset", {7'h00, mcu_reset}, 8'h00);
      repeat (TICK + 8) @(negedge sys_clk);
      chk("timeout reset", {7'h00, mcu_reset}, 8'h01);
      @(negedge mcu_reset);
      @(posedge sys_clk);
      rd(8'hFB, 8'h81, "timeout cause");
      // firmware restarts the counter before going quiet
      mcu.acc(1'b1, 8'hFB, 8'h81, q);
      rd(8'hFB, 8'h01, "cause clear");
      // debugger break holds the counter
      debug_enable = 1;
      debug_break  = 1;
      repeat (TO_CYC + 4) @(negedge sys_clk);
      chk("suspended", {7'h00, mcu_reset}, 8'h00);
      debug_break = 0;
      app_jump    = 1;
      @(negedge sys_clk) app_jump = 0;
      repeat (TO_CYC + 4) @(negedge sys_clk);
      chk("resumed", {7'h00, mcu_reset}, 8'h01);
      @(negedge mcu_reset);
      @(posedge sys_clk);
      mcu.acc(1'b1, 8'hFB, 8'h80, q);
      // key write stops the watchdog until the next power-up reset
      mcu.acc(1'b1, 8'hFB, 8'h54, q);
      rd(8'hFB, 8'h00, "disable");
      repeat (TO_CYC + 4) @(negedge sys_clk);
      chk("disabled", {7'h00, mcu_reset}, 8'h00);
      usb_reset = 1;
      mcu.acc(1'b1, 8'hFB, 8'h01, q);
      usb_reset = 0;
      rd(8'hFB, 8'h00, "usb reset");
      reset = 1;
      repeat (2) @(negedge sys_clk);
      reset = 0;
      rd(8'hFB, 8'h01, "power reset");
      end_of_test();
   end
endmodule : tb_mcu_watchdog_timer
